// *** rtl/hmap_pkg.sv ***
package hmap_pkg;
	localparam int          HMAP_DW          = 16;
	localparam int          HMAP_AW          = 14;
	localparam logic [15:0] HMAP_OVL_ADDR    = 16'h3FE7;
	localparam int          HMAP_SRO_BIT     = 14;
	localparam logic [15:0] HMAP_OVL_RESET   = 16'h0000;
	localparam logic [13:0] HMAP_ADDR_STEP   = 14'h0001;
	// address bit 14 selects program memory, as in the latch word
	localparam int          HMAP_PM_BIT      = 14;
	localparam int          HMAP_CLK_PS      = 20000;
	// earliest ack low after write start: 1.5 clock periods, rounded up
	localparam int          HMAP_WACK_PS     = 30000;
	localparam int          HMAP_WACK_CYC    =
		(HMAP_WACK_PS + HMAP_CLK_PS - 1) / HMAP_CLK_PS;
	// previous data hold: 2t for data/first half, t for second half
	localparam int          HMAP_HOLD1_CYC   = 2;
	localparam int          HMAP_HOLD2_CYC   = 1;
	localparam logic [2:0]  HMAP_CNT_ONE     = 3'h1;
	typedef enum logic [2:0] {
		HMAP_IDLE  = 3'b000,
		HMAP_WRITE = 3'b001,
		HMAP_WDONE = 3'b010,
		HMAP_READ  = 3'b011,
		HMAP_RDONE = 3'b100
	} hmap_state_e;
endpackage

// *** rtl/hmap_if.sv ***
`timescale 1ns/100ps
// pins of the host memory port; enables are active low
interface hmap_if;
	logic        port_select_n;
	logic        address_latch_strobe;
	logic        port_write_strobe_n;
	logic        port_read_strobe_n;
	logic        port_acknowledge_n;
	logic [15:0] bus_dev;
	logic        bus_dev_oe_n;
	logic [15:0] bus_host;
	logic        bus_host_oe_n;
	wire  [15:0] shared_addr_data_bus;
	assign shared_addr_data_bus = !bus_dev_oe_n ? bus_dev :
		(!bus_host_oe_n ? bus_host : 16'hFFFF);
	modport device (
		input  port_select_n, address_latch_strobe, port_write_strobe_n,
		input  port_read_strobe_n, shared_addr_data_bus,
		output port_acknowledge_n, bus_dev, bus_dev_oe_n
	);
	modport host (
		output port_select_n, address_latch_strobe, port_write_strobe_n,
		output port_read_strobe_n, bus_host, bus_host_oe_n,
		input  port_acknowledge_n, shared_addr_data_bus
	);
endinterface

// *** rtl/hmap_sync.sv ***
`timescale 1ns/100ps
// three-flop synchroniser; change taken once stages two and three agree
module hmap_sync (
	input  wire logic i_clock,   // system clock
	input  wire logic i_resetn,  // async reset, active low
	input  wire logic i_enable,  // clock enable
	input  wire logic i_init,    // value held through reset
	input  wire logic i_async,   // pin input
	output logic      o_level    // filtered level
);
	logic [2:0] stage;
	logic       lvl;
	// stages hold the pin relative to its idle level, so a reset
	// of all zeros reads as idle and no false strobe follows reset
	// first stage feeds only the second
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			stage <= 3'h0;
			lvl   <= 1'b0;
		end else if (i_enable) begin
			stage <= {stage[1:0], i_async ^ i_init};
			if (stage[1] == stage[2])
				lvl <= stage[2];
		end
	end
	// back to pin polarity
	assign o_level = lvl ^ i_init;
endmodule

// *** rtl/hmap_device.sv ***
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
// device end: latches address, runs read and write cycles on the memory
module hmap_device import hmap_pkg::*; (
	input  wire logic          i_clock,      // system clock
	input  wire logic          i_resetn,     // async reset, active low
	input  wire logic          i_enable,     // clock enable
	input  wire logic          i_mode_strap, // host-mode strap pin
	hmap_if.device             port,         // host port pins
	input  wire logic          i_core_wr,    // core overlay write strobe
	input  wire logic [15:0]   i_core_wdata, // core overlay write data
	output logic               o_host_mode,  // strap latched after reset release
	output logic               o_short_ro,   // short-read-only state
	output logic [15:0]        o_address     // current latched address
);
	logic s_sel_n, s_al, s_wr_n, s_rd_n;
	logic [15:0] bus_in;
	logic        strap_taken;
	hmap_state_e state;
	logic [15:0] overlay;
	logic [15:0] prev_word;
	logic [2:0]  cnt;
	logic [15:0] dmem [0:(1<<HMAP_AW)-1];
	logic [15:0] pmem_lo [0:(1<<HMAP_AW)-1];
	logic [15:0] pmem_hi [0:(1<<HMAP_AW)-1];
	logic        half;  // next program access is the second half
	logic        latch_q;
	logic        ack_q;
	logic [15:0] drv;
	logic        drv_oe_n;

	hmap_sync u_sel (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_enable(i_enable), .i_init(1'b1),
		.i_async(port.port_select_n), .o_level(s_sel_n));
	hmap_sync u_al (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_enable(i_enable), .i_init(1'b0),
		.i_async(port.address_latch_strobe), .o_level(s_al));
	hmap_sync u_wr (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_enable(i_enable), .i_init(1'b1),
		.i_async(port.port_write_strobe_n), .o_level(s_wr_n));
	hmap_sync u_rd (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_enable(i_enable), .i_init(1'b1),
		.i_async(port.port_read_strobe_n), .o_level(s_rd_n));

	// bus sampled at the pins; the synchronised strobes qualify it
	assign bus_in = port.shared_addr_data_bus;

	// phase decodes; sync flops reset low so guard with strap_taken
	wire latch_on = strap_taken && !s_sel_n && s_al;
	wire latch_end = latch_q && !latch_on;
	wire wr_on = strap_taken && !s_sel_n && !s_wr_n;
	wire rd_on = strap_taken && !s_sel_n && !s_rd_n;
	wire port_on = o_host_mode;
	wire is_pm = o_address[HMAP_PM_BIT];
	wire [13:0] waddr = o_address[HMAP_AW-1:0];
	wire [2:0] hold_cyc = (is_pm && half) ? 3'(HMAP_HOLD2_CYC)
		: 3'(HMAP_HOLD1_CYC);
	wire is_ovl = o_address == HMAP_OVL_ADDR;
	wire [15:0] fetched = is_ovl ? overlay : (!is_pm ? dmem[waddr]
		: (half ? pmem_hi[waddr] : pmem_lo[waddr]));
	wire [15:0] next_addr = o_address + 16'(HMAP_ADDR_STEP);
	wire advance = !is_pm || half;

	// strap caught by a clocked process after reset release
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			strap_taken <= 1'b0;
			o_host_mode <= 1'b0;
		end else if (i_enable && !strap_taken) begin
			strap_taken <= 1'b1;
			o_host_mode <= i_mode_strap;
		end
	end

	// main cycle machine
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			state     <= HMAP_IDLE;
			latch_q   <= 1'b0;
			o_address <= 16'h0000;
			overlay   <= HMAP_OVL_RESET;
			prev_word <= 16'h0000;
			cnt       <= 3'h0;
			half      <= 1'b0;
			ack_q     <= 1'b0;
			drv       <= 16'h0000;
			drv_oe_n  <= 1'b1;
		end else if (i_enable) begin
			latch_q <= latch_on && port_on;
			if (i_core_wr)
				overlay <= i_core_wdata;
			if (latch_end && state == HMAP_IDLE) begin
				o_address <= bus_in;
				half      <= 1'b0;
			end
			case (state)
			HMAP_IDLE: begin
				drv_oe_n <= 1'b1;
				if (port_on && wr_on) begin
					ack_q <= 1'b1;
					cnt   <= 3'(HMAP_WACK_CYC);
					state <= HMAP_WRITE;
				end else if (port_on && rd_on) begin
					ack_q    <= 1'b1;
					drv      <= prev_word;
					drv_oe_n <= 1'b0;
					cnt      <= hold_cyc;
					state    <= HMAP_READ;
				end
			end
			HMAP_WRITE: begin
				// write on strobe end (short) or count end (long)
				if (!wr_on || cnt <= HMAP_CNT_ONE) begin
					if (is_ovl)
						overlay <= bus_in;
					else if (!is_pm)
						dmem[waddr] <= bus_in;
					else if (half)
						pmem_hi[waddr] <= bus_in;
					else
						pmem_lo[waddr] <= bus_in;
					half <= is_pm && !half;
					if (advance)
						o_address <= next_addr;
					ack_q <= 1'b0;
					state <= HMAP_WDONE;
				end else
					cnt <= cnt - HMAP_CNT_ONE;
			end
			HMAP_WDONE:
				if (!wr_on)
					state <= HMAP_IDLE;
			HMAP_READ: begin
				if (!rd_on) begin
					drv_oe_n <= 1'b1;
					ack_q    <= 1'b0;
					state    <= HMAP_IDLE;
				end else if (cnt > HMAP_CNT_ONE)
					cnt <= cnt - HMAP_CNT_ONE;
				else begin
					// in short-read-only the previous word stays
					if (!overlay[HMAP_SRO_BIT])
						drv <= fetched;
					prev_word <= fetched;
					half <= is_pm && !half;
					if (advance)
						o_address <= next_addr;
					state <= HMAP_RDONE;
				end
			end
			HMAP_RDONE: begin
				// ack drops one cycle after new word, >= 0.5t
				ack_q <= 1'b0;
				if (!rd_on) begin
					drv_oe_n <= 1'b1;
					state    <= HMAP_IDLE;
				end
			end
			default: state <= HMAP_IDLE;
			endcase
		end
	end

	// pin high while busy, low when ready for the next access
	assign port.port_acknowledge_n = ack_q;
	assign port.bus_dev            = drv;
	assign port.bus_dev_oe_n       = drv_oe_n;
	assign o_short_ro              = overlay[HMAP_SRO_BIT];
endmodule

// *** rtl/hmap_host.sv ***
`timescale 1ns/100ps
// host end: runs one port cycle per user command
module hmap_host import hmap_pkg::*; (
	input  wire logic        i_clock,   // system clock
	input  wire logic        i_resetn,  // async reset, active low
	input  wire logic        i_enable,  // clock enable
	hmap_if.host             port,      // port pins
	input  wire logic        i_latch,   // pulse: latch i_wdata as address
	input  wire logic        i_write,   // pulse: write i_wdata
	input  wire logic        i_read,    // pulse: read a word
	input  wire logic [15:0] i_wdata,   // address or write data
	output logic             o_busy,    // cycle in progress
	output logic             o_rvalid,  // pulse: o_rdata valid
	output logic [15:0]      o_rdata    // read word
);
	typedef enum logic [2:0] {
		HMAP_H_IDLE = 3'b000, HMAP_H_LAT = 3'b001, HMAP_H_WR = 3'b010,
		HMAP_H_RD = 3'b011, HMAP_H_END = 3'b100
	} hmap_hstate_e;
	hmap_hstate_e st;
	logic ack_n;
	logic sel_n, al, wr_n, rd_n, oe_n, seen_ack;
	logic [15:0] dout;
	logic [2:0]  hcnt;
	// latch strobe spans enough cycles for the device's input filter;
	// the address stays driven well past the strobe end
	localparam logic [2:0] HMAP_LAT_LEN  = 3'h7;
	localparam logic [2:0] HMAP_LAT_DROP = 3'h5;
	localparam logic [2:0] HMAP_LAT_DONE = 3'h0;
	hmap_sync u_ack (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_enable(i_enable), .i_init(1'b0),
		.i_async(port.port_acknowledge_n), .o_level(ack_n));
	wire ack_low = !ack_n;
	// host only starts with acknowledge low and after latch end
	wire start_ok = !o_busy && ack_low;
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			st <= HMAP_H_IDLE; sel_n <= 1'b1; al <= 1'b0; wr_n <= 1'b1;
			rd_n <= 1'b1; oe_n <= 1'b1; dout <= 16'h0000; o_busy <= 1'b0;
			o_rvalid <= 1'b0; o_rdata <= 16'h0000; seen_ack <= 1'b0;
			hcnt <= 3'h0;
		end else if (i_enable) begin
			o_rvalid <= 1'b0;
			case (st)
			HMAP_H_IDLE:
				if (start_ok && (i_latch || i_write || i_read)) begin
					o_busy <= 1'b1; sel_n <= 1'b0; dout <= i_wdata;
					seen_ack <= 1'b0;
					oe_n <= i_read;
					if (i_latch) begin
						al <= 1'b1; st <= HMAP_H_LAT;
						hcnt <= HMAP_LAT_LEN;
					end else if (i_write) begin
						wr_n <= 1'b0; st <= HMAP_H_WR;
					end else begin
						rd_n <= 1'b0; st <= HMAP_H_RD;
					end
				end
			// a one-cycle strobe would be filtered out by the device
			HMAP_H_LAT: begin
				hcnt <= hcnt - HMAP_CNT_ONE;
				if (hcnt == HMAP_LAT_DROP) begin
					al <= 1'b0;
					sel_n <= 1'b1;
				end
				if (hcnt == HMAP_LAT_DONE)
					st <= HMAP_H_END;
			end
			// long cycles: wait for ack high then low (short-read-only
			// preferred over bounded short reads)
			HMAP_H_WR, HMAP_H_RD: begin
				if (!ack_n)
					seen_ack <= 1'b0;
				if (ack_n)
					seen_ack <= 1'b1;
				if (seen_ack && !ack_n) begin
					o_rdata <= port.shared_addr_data_bus;
					o_rvalid <= (st == HMAP_H_RD);
					wr_n <= 1'b1; rd_n <= 1'b1; sel_n <= 1'b1;
					st <= HMAP_H_END;
				end
			end
			HMAP_H_END: begin
				oe_n <= 1'b1; o_busy <= 1'b0; st <= HMAP_H_IDLE;
			end
			default: st <= HMAP_H_IDLE;
			endcase
		end
	end
	assign port.port_select_n        = sel_n;
	assign port.address_latch_strobe = al;
	assign port.port_write_strobe_n  = wr_n;
	assign port.port_read_strobe_n   = rd_n;
	assign port.bus_host             = dout;
	assign port.bus_host_oe_n        = oe_n;
endmodule

// *** verification/hmap_chk.sv ***
`timescale 1ns/100ps
// pin checks on the port joining the two ends
module hmap_chk (
	input wire logic        i_clock,              // clock
	input wire logic        i_resetn,             // reset, low
	input wire logic        port_select_n,        // select
	input wire logic        address_latch_strobe, // latch
	input wire logic        port_write_strobe_n,  // write
	input wire logic        port_read_strobe_n,   // read
	input wire logic        port_acknowledge_n,   // ack
	input wire logic [15:0] bus_dev,              // device data
	input wire logic        bus_dev_oe_n,         // device drives
	input wire logic [15:0] bus_host,             // host data
	input wire logic        bus_host_oe_n         // host drives
);
	// access windows as seen on the pins
	wire wr_on = !port_select_n && !port_write_strobe_n;
	wire rd_on = !port_select_n && !port_read_strobe_n;
	wire al_on = !port_select_n && address_latch_strobe;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	// bounds allow for the three-flop input synchroniser
	property p_wr_ack;
		$rose(wr_on) |-> ##[1:8] port_acknowledge_n;
	endproperty
	a_wr_ack: assert property (p_wr_ack)
		else $error("write ack not raised");
	property p_wr_min;
		$rose(port_acknowledge_n) && wr_on |-> port_acknowledge_n[*2];
	endproperty
	a_wr_min: assert property (p_wr_min)
		else $error("write ack dropped too early");
	property p_wr_end;
		$rose(port_write_strobe_n) |-> ##[0:8] !port_acknowledge_n;
	endproperty
	a_wr_end: assert property (p_wr_end)
		else $error("ack stuck after write");
	property p_wr_hold;
		wr_on && $past(wr_on) && !bus_host_oe_n |-> $stable(bus_host);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write data moved in strobe");
	property p_rd_ack;
		$rose(rd_on) |-> ##[1:8] port_acknowledge_n;
	endproperty
	a_rd_ack: assert property (p_rd_ack)
		else $error("read ack not raised");
	property p_rd_drv;
		$rose(rd_on) |-> ##[1:8] !bus_dev_oe_n;
	endproperty
	a_rd_drv: assert property (p_rd_drv)
		else $error("read word not driven");
	property p_rd_hold;
		rd_on && !port_acknowledge_n && !bus_dev_oe_n && $past(!bus_dev_oe_n)
			|-> $stable(bus_dev);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read word moved before end");
	property p_rd_rel;
		$rose(port_read_strobe_n) |-> ##[1:8] bus_dev_oe_n;
	endproperty
	a_rd_rel: assert property (p_rd_rel)
		else $error("bus not released");
	property p_latch;
		$rose(al_on) |-> !port_acknowledge_n;
	endproperty
	a_latch: assert property (p_latch)
		else $error("latch while ack high");
endmodule

// *** verification/tb_host_memory_access_port.sv ***
`timescale 1ns/100ps
// host end and device end joined; user sides driven here
module tb_host_memory_access_port import hmap_pkg::*;;
	logic        i_clock = 1'b0;
	logic        i_resetn = 1'b0;
	logic        i_mode_strap = 1'b1;
	logic        i_core_wr = 1'b0;
	logic        i_latch = 1'b0, i_write = 1'b0, i_read = 1'b0;
	logic [15:0] i_wdata = 16'h0000;
	logic        o_host_mode, o_short_ro, o_busy, o_rvalid;
	logic [15:0] o_address, o_rdata;
	logic [15:0] exp_q[$];
	logic [15:0] wd[4];
	logic [31:0] seed = 32'h00000011;
	int          bad_count = 0, checks = 0, cycles = 0;
	always #10 i_clock = ~i_clock;
	hmap_if bus_if ();
	hmap_device u_hmap_device (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_enable(1'b1), .i_mode_strap(i_mode_strap), .port(bus_if),
		.i_core_wr(i_core_wr), .i_core_wdata(16'h0000),
		.o_host_mode(o_host_mode), .o_short_ro(o_short_ro),
		.o_address(o_address));
	hmap_host u_hmap_host (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_enable(1'b1), .port(bus_if), .i_latch(i_latch),
		.i_write(i_write), .i_read(i_read), .i_wdata(i_wdata),
		.o_busy(o_busy), .o_rvalid(o_rvalid), .o_rdata(o_rdata));
	hmap_chk u_hmap_chk (.i_clock(i_clock), .i_resetn(i_resetn),
		.port_select_n(bus_if.port_select_n),
		.address_latch_strobe(bus_if.address_latch_strobe),
		.port_write_strobe_n(bus_if.port_write_strobe_n),
		.port_read_strobe_n(bus_if.port_read_strobe_n),
		.port_acknowledge_n(bus_if.port_acknowledge_n),
		.bus_dev(bus_if.bus_dev), .bus_dev_oe_n(bus_if.bus_dev_oe_n),
		.bus_host(bus_if.bus_host), .bus_host_oe_n(bus_if.bus_host_oe_n));
	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction
	task complete_run();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task check(input string nm, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one host command; gap lets the device see the last strobe end
	task cmd(input logic [2:0] k, input logic [15:0] d);
		repeat (6) @(posedge i_clock);
		while (bus_if.port_acknowledge_n !== 1'b0) @(posedge i_clock);
		{i_read, i_write, i_latch} <= k;
		i_wdata <= d;
		@(posedge i_clock);
		{i_read, i_write, i_latch} <= 3'h0;
		#1;
		while (o_busy !== 1'b0) @(posedge i_clock) #1;
	endtask
	// bounded wait for the address and mode bit to land
	task settle(input logic [15:0] ea, input logic es);
		for (int n = 0; n < 20 && (o_address !== ea || o_short_ro !== es);
			n++) @(posedge i_clock) #1;
		check("address", o_address, ea);
		check("short_ro", {15'h0, o_short_ro}, {15'h0, es});
	endtask
	// read results against the oldest note; hang guard
	always @(posedge i_clock) begin
		cycles++;
		if (o_rvalid === 1'b1)
			check("rdata", o_rdata, exp_q.size() ? exp_q.pop_front()
				: 16'hXXXX);
		if (cycles == 5000) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		logic [15:0] a;
		repeat (2) @(posedge i_clock);
		i_resetn <= 1'b1;
		repeat (4) @(posedge i_clock);
		#1;
		check("host_mode", {15'h0, o_host_mode}, 16'h0001);
		check("short_ro", {15'h0, o_short_ro}, 16'h0000);
		// data memory, then program memory in halves
		for (int p = 0; p < 2; p++) begin
			a = rnd() & 16'h1FFF | (p ? 16'h4000 : 16'h0000);
			cmd(3'h1, a);
			settle(a, 1'b0);
			for (int i = 0; i < 4; i++) begin
				wd[i] = rnd();
				cmd(3'h2, wd[i]);
				settle(a + 16'(p ? (i + 1) / 2 : i + 1), 1'b0);
			end
			cmd(3'h1, a);
			for (int i = 0; i < 4; i++) begin
				exp_q.push_back(wd[i]);
				cmd(3'h4, 16'h0000);
			end
			$display("test %0d memory readback done", p);
		end
		// mode bit set by host, cleared by core
		cmd(3'h1, HMAP_OVL_ADDR);
		cmd(3'h2, 16'h4000);
		settle(HMAP_OVL_ADDR + 16'h0001, 1'b1);
		i_core_wr <= 1'b1;
		@(posedge i_clock);
		i_core_wr <= 1'b0;
		settle(HMAP_OVL_ADDR + 16'h0001, 1'b0);
		$display("test 2 overlay done");
		i_mode_strap <= 1'b0;
		i_resetn <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_resetn <= 1'b1;
		repeat (4) @(posedge i_clock);
		#1;
		check("host_mode", {15'h0, o_host_mode}, 16'h0000);
		check("short_ro", {15'h0, o_short_ro}, 16'h0000);
		check("pending", 16'(exp_q.size()), 16'h0000);
		$display("test 3 strap done");
		complete_run();
	end
endmodule
